// File: src/cci_params.svh
`ifndef CCI_PARAMS_SVH
`define CCI_PARAMS_SVH
// ---------------------------------------------------------------
// operating_conditions field positions
// ---------------------------------------------------------------
`define CCI_OCR_POWERUP_BIT   31
`define CCI_OCR_CAPACITY_BIT  30
`define CCI_OCR_LVSWITCH_BIT  24
`define CCI_OCR_VWIN_HI       23
`define CCI_OCR_VWIN_LO       15
`define CCI_OCR_DUALV_BIT     7
`define CCI_OCR_RESET         32'h0000_0000
// ---------------------------------------------------------------
// card_identification field positions
// ---------------------------------------------------------------
`define CCI_CID_MAKER_HI      127
`define CCI_CID_MAKER_LO      120
`define CCI_CID_APPV_HI       119
`define CCI_CID_APPV_LO       104
`define CCI_CID_PNAME_HI      103
`define CCI_CID_PNAME_LO      64
`define CCI_CID_PREV_HI       63
`define CCI_CID_PREV_LO       56
`define CCI_CID_SERIAL_HI     55
`define CCI_CID_SERIAL_LO     24
`define CCI_CID_RSVD_HI       23
`define CCI_CID_RSVD_LO       20
`define CCI_CID_YEAR_HI       19
`define CCI_CID_YEAR_LO       12
`define CCI_CID_MONTH_HI      11
`define CCI_CID_MONTH_LO      8
`define CCI_CID_CRC_HI        7
`define CCI_CID_CRC_LO        1
`define CCI_CID_STOP_BIT      0
// ---------------------------------------------------------------
// crc walk
// ---------------------------------------------------------------
`define CCI_CRC_BITS          120
`define CCI_CID_BODY_OFS      8
`define CCI_CRC_POLY          7'h09
`endif

// File: src/cci_pkg.sv
package cci_pkg;
   typedef enum logic [3:0] {
      CCI_IDLE = 4'h1,
      CCI_CRC  = 4'h2,
      CCI_RDY  = 4'h4,
      CCI_HOLD = 4'h8
   } cci_state_e;
   typedef enum logic [1:0] {
      CCI_SEL_NONE = 2'h0,
      CCI_SEL_OCR  = 2'h1,
      CCI_SEL_CID  = 2'h2
   } cci_sel_e;
endpackage : cci_pkg

// File: src/cci_card_regs.sv
`timescale 1ns/1ps
`include "cci_params.svh"
module cci_card_regs #(
   parameter logic [7:0]  MAKER_CODE   = 8'h5A,          // arbitrary value
   parameter logic [15:0] APP_CODE     = 16'h4142,       // arbitrary value
   parameter logic [39:0] PRODUCT_NAME = 40'h4341_5244_30,
   parameter logic [7:0]  PRODUCT_REV  = 8'h10,
   parameter logic [8:0]  VOLT_WINDOW  = 9'h1FF,
   parameter logic        HIGH_CAP     = 1'b1,
   parameter logic        LV_CAPABLE   = 1'b1
) (
   input  wire logic         core_clk_in,
   input  wire logic         reset_in,
   input  wire logic         clk_en_in,
   input  wire logic         powerup_done_in,
   input  wire logic         dualv_check_in,
   input  wire logic         lv_switch_ok_in,
   input  wire logic [31:0]  serial_in,
   input  wire logic [7:0]   year_in,
   input  wire logic [3:0]   month_in,
   input  wire logic         rd_ocr_in,
   input  wire logic         rd_cid_in,
   output logic              rd_valid_out,
   output logic [127:0]      rd_data_out,
   output logic              cid_ready_out
);
   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   function automatic logic [6:0] crc7_step(input logic [6:0] crc, input logic bit_in);
      logic fb;
      fb = crc[6] ^ bit_in;
      crc7_step = {crc[5:0], 1'b0} ^ (fb ? `CCI_CRC_POLY : 7'h00);
   endfunction : crc7_step

   // ---------------------------------------------------------------
   // pin synchronisers (status strobes come from analog/power domain)
   // ---------------------------------------------------------------
   logic [2:0] pu_sync_ff;
   logic [2:0] nxt_pu_sync;
   logic [2:0] lv_sync_ff;
   logic [2:0] nxt_lv_sync;
   logic       pu_ff;
   logic       nxt_pu;
   logic       lv_ff;
   logic       nxt_lv;

   always_comb begin
      nxt_pu_sync = {pu_sync_ff[1:0], powerup_done_in};
      nxt_lv_sync = {lv_sync_ff[1:0], lv_switch_ok_in};
      nxt_pu      = (pu_sync_ff[2] == pu_sync_ff[1]) ? pu_sync_ff[1] : pu_ff;
      nxt_lv      = (lv_sync_ff[2] == lv_sync_ff[1]) ? lv_sync_ff[1] : lv_ff;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         pu_sync_ff <= 3'h0;
         lv_sync_ff <= 3'h0;
         pu_ff      <= 1'b0;
         lv_ff      <= 1'b0;
      end else if (clk_en_in) begin
         pu_sync_ff <= nxt_pu_sync;
         lv_sync_ff <= nxt_lv_sync;
         pu_ff      <= nxt_pu;
         lv_ff      <= nxt_lv;
      end
   end

   // ---------------------------------------------------------------
   // operating_conditions
   // ---------------------------------------------------------------
   logic [31:0] ocr_ff;
   logic [31:0] nxt_ocr;
   logic        dualv_ff;
   logic        nxt_dualv;

   always_comb begin
      // sticky: once the voltage check arrives it holds until reset
      nxt_dualv = dualv_ff | dualv_check_in;
      nxt_ocr   = `CCI_OCR_RESET;
      nxt_ocr[`CCI_OCR_DUALV_BIT] = dualv_ff;
      nxt_ocr[`CCI_OCR_VWIN_HI:`CCI_OCR_VWIN_LO] = VOLT_WINDOW;
      nxt_ocr[`CCI_OCR_LVSWITCH_BIT] = LV_CAPABLE & lv_ff;
      nxt_ocr[`CCI_OCR_POWERUP_BIT]  = pu_ff;
      // capacity held low while busy so host never sees a stale class
      nxt_ocr[`CCI_OCR_CAPACITY_BIT] = pu_ff & HIGH_CAP;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ocr_ff   <= `CCI_OCR_RESET;
         dualv_ff <= 1'b0;
      end else if (clk_en_in) begin
         ocr_ff   <= nxt_ocr;
         dualv_ff <= nxt_dualv;
      end
   end

   // ---------------------------------------------------------------
   // card_identification: crc is walked serially after reset
   // ---------------------------------------------------------------
   cci_pkg::cci_state_e st_ff;
   cci_pkg::cci_state_e nxt_st;
   localparam int       OFS = `CCI_CID_BODY_OFS;
   logic [119:0]        body;
   logic [6:0]          crc_ff;
   logic [6:0]          nxt_crc;
   logic [6:0]          cnt_ff;
   logic [6:0]          nxt_cnt;
   logic [127:0]        cid_ff;
   logic [127:0]        nxt_cid;

   always_comb begin
      body = '0;
      body[`CCI_CID_MAKER_HI-OFS:`CCI_CID_MAKER_LO-OFS]   = MAKER_CODE;
      body[`CCI_CID_APPV_HI-OFS:`CCI_CID_APPV_LO-OFS]     = APP_CODE;
      body[`CCI_CID_PNAME_HI-OFS:`CCI_CID_PNAME_LO-OFS]   = PRODUCT_NAME;
      body[`CCI_CID_PREV_HI-OFS:`CCI_CID_PREV_LO-OFS]     = PRODUCT_REV;
      body[`CCI_CID_SERIAL_HI-OFS:`CCI_CID_SERIAL_LO-OFS] = serial_in;
      body[`CCI_CID_RSVD_HI-OFS:`CCI_CID_RSVD_LO-OFS]     = 4'h0;
      body[`CCI_CID_YEAR_HI-OFS:`CCI_CID_YEAR_LO-OFS]     = year_in;
      body[`CCI_CID_MONTH_HI-OFS:`CCI_CID_MONTH_LO-OFS]   = month_in;
   end

   always_comb begin
      nxt_st  = st_ff;
      nxt_crc = crc_ff;
      nxt_cnt = cnt_ff;
      nxt_cid = cid_ff;
      case (st_ff)
         cci_pkg::CCI_IDLE: begin
            nxt_crc = 7'h00;
            nxt_cnt = 7'h00;
            nxt_st  = cci_pkg::CCI_CRC;
         end
         cci_pkg::CCI_CRC: begin
            nxt_crc = crc7_step(crc_ff, body[7'(`CCI_CRC_BITS - 1) - cnt_ff]);
            nxt_cnt = cnt_ff + 7'h01;
            if (cnt_ff == 7'(`CCI_CRC_BITS - 1)) begin
               nxt_st = cci_pkg::CCI_RDY;
            end
         end
         cci_pkg::CCI_RDY: begin
            nxt_cid = {body, crc_ff, 1'b1};
            nxt_st  = cci_pkg::CCI_HOLD;
         end
         cci_pkg::CCI_HOLD: begin
            // identity straps are only captured once per reset
            nxt_st = cci_pkg::CCI_HOLD;
         end
         default: begin
            nxt_st = cci_pkg::CCI_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st_ff  <= cci_pkg::CCI_IDLE;
         crc_ff <= 7'h00;
         cnt_ff <= 7'h00;
         cid_ff <= 128'h0;
      end else if (clk_en_in) begin
         st_ff  <= nxt_st;
         crc_ff <= nxt_crc;
         cnt_ff <= nxt_cnt;
         cid_ff <= nxt_cid;
      end
   end

   // ---------------------------------------------------------------
   // command read port: no address, only the two read commands
   // ---------------------------------------------------------------
   logic         rd_valid_ff;
   logic         nxt_rd_valid;
   logic [127:0] rd_data_ff;
   logic [127:0] nxt_rd_data;
   logic         cid_ready_ff;
   logic         nxt_cid_ready;

   always_comb begin
      nxt_cid_ready = (st_ff == cci_pkg::CCI_HOLD);
      nxt_rd_valid  = 1'b0;
      nxt_rd_data   = rd_data_ff;
      // identification wins if both commands arrive together once cid_ready_ff is set; before that the OCR read is answered
      if (rd_cid_in && cid_ready_ff) begin
         nxt_rd_valid = 1'b1;
         nxt_rd_data  = cid_ff;
      end else if (rd_ocr_in) begin
         nxt_rd_valid = 1'b1;
         nxt_rd_data  = {96'h0, ocr_ff};
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rd_valid_ff  <= 1'b0;
         rd_data_ff   <= 128'h0;
         cid_ready_ff <= 1'b0;
      end else if (clk_en_in) begin
         rd_valid_ff  <= nxt_rd_valid;
         rd_data_ff   <= nxt_rd_data;
         cid_ready_ff <= nxt_cid_ready;
      end
   end

   assign rd_valid_out  = rd_valid_ff;
   assign rd_data_out   = rd_data_ff;
   assign cid_ready_out = cid_ready_ff;
endmodule : cci_card_regs

// File: verif/cci_card_regs_chk.sv
`timescale 1ns/1ps
module cci_card_regs_chk #(
   parameter logic [71:0] ID_HEAD     = 72'h5A_4142_4341524430_10,
   parameter logic [8:0]  VOLT_WINDOW = 9'h1FF
) (
   input wire logic         core_clk_in,
   input wire logic         reset_in,
   input wire logic         clk_en_in,
   input wire logic         powerup_done_in,
   input wire logic         dualv_check_in,
   input wire logic         lv_switch_ok_in,
   input wire logic [31:0]  serial_in,
   input wire logic [7:0]   year_in,
   input wire logic [3:0]   month_in,
   input wire logic         rd_ocr_in,
   input wire logic         rd_cid_in,
   input wire logic         rd_valid_out,
   input wire logic [127:0] rd_data_out,
   input wire logic         cid_ready_out
);
   // ---------
   // answers
   // ---------
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   sequence s_ocr; clk_en_in && rd_ocr_in && !rd_cid_in; endsequence
   sequence s_cid; clk_en_in && rd_cid_in && cid_ready_out; endsequence
   property p_ans; clk_en_in && (rd_ocr_in || (rd_cid_in && cid_ready_out)) |=> rd_valid_out;
   endproperty
   property p_refuse; clk_en_in && rd_cid_in && !cid_ready_out && !rd_ocr_in |=> !rd_valid_out;
   endproperty
   property p_pulse; rd_valid_out && clk_en_in && !rd_ocr_in && !rd_cid_in |=> !rd_valid_out;
   endproperty
   property p_ocr; s_ocr |=> rd_data_out[127:32] == 96'h0 && rd_data_out[29:25] == 5'h0
      && rd_data_out[14:8] == 7'h0 && rd_data_out[6:0] == 7'h0
      && rd_data_out[23:15] == VOLT_WINDOW && (!rd_data_out[30] || rd_data_out[31]);
   endproperty
   property p_pu_lo; (clk_en_in && !powerup_done_in) [*8] ##0 s_ocr |=> !rd_data_out[31];
   endproperty
   property p_pu_hi; (clk_en_in && powerup_done_in) [*8] ##0 s_ocr |=> rd_data_out[31];
   endproperty
   property p_head; s_cid |=> rd_data_out[127:56] == ID_HEAD; endproperty
   property p_body; s_cid |=> rd_data_out[55:8] == {serial_in, 4'h0, year_in, month_in};
   endproperty
   property p_tail; s_cid |=> rd_data_out[0] && rd_data_out[23:20] == 4'h0; endproperty
   property p_ready; cid_ready_out |=> cid_ready_out; endproperty
   a_ans: assert property (p_ans) else $error("read not answered");
   a_refuse: assert property (p_refuse) else $error("early id read answered");
   a_pulse: assert property (p_pulse) else $error("valid too long");
   a_ocr: assert property (p_ocr) else $error("condition fields wrong");
   a_pu_lo: assert property (p_pu_lo) else $error("power-up bit early");
   a_pu_hi: assert property (p_pu_hi) else $error("power-up bit missing");
   a_head: assert property (p_head) else $error("id head wrong");
   a_body: assert property (p_body) else $error("id body wrong");
   a_tail: assert property (p_tail) else $error("id tail wrong");
   a_ready: assert property (p_ready) else $error("ready dropped");
endmodule : cci_card_regs_chk
bind cci_card_regs cci_card_regs_chk #(
   .ID_HEAD({MAKER_CODE, APP_CODE, PRODUCT_NAME, PRODUCT_REV}),
   .VOLT_WINDOW(VOLT_WINDOW)
) u_chk (.core_clk_in, .reset_in, .clk_en_in, .powerup_done_in, .dualv_check_in,
   .lv_switch_ok_in, .serial_in, .year_in, .month_in, .rd_ocr_in, .rd_cid_in,
   .rd_valid_out, .rd_data_out, .cid_ready_out);

// File: verif/cci_host_model.sv
`timescale 1ns/1ps
module cci_host_model (
   input  wire logic         core_clk_in,
   input  wire logic         rd_valid_in,
   input  wire logic [127:0] rd_data_in,
   output logic              rd_ocr_out,
   output logic              rd_cid_out
);
   initial {rd_cid_out, rd_ocr_out} = 2'h0;
   // one-cycle command; answer due one cycle later
   task automatic cmd(input logic [1:0] k, output logic ok, output logic [127:0] d);
      @(negedge core_clk_in);
      {rd_cid_out, rd_ocr_out} = k;
      @(negedge core_clk_in);
      {rd_cid_out, rd_ocr_out} = 2'h0;
      ok = rd_valid_in;
      d = rd_data_in;
   endtask : cmd
endmodule : cci_host_model

// File: verif/cci_card_regs_test.sv
`timescale 1ns/1ps
module cci_card_regs_test;
   logic         core_clk_in, reset_in, clk_en_in, pu, dv, lv, dvs, rd_ocr, rd_cid, vld, rdy, ok;
   logic [31:0]  serial;
   logic [7:0]   year;
   logic [3:0]   month;
   logic [127:0] data, got;
   int           num_errors, compares;
   cci_card_regs dut (.core_clk_in, .reset_in, .clk_en_in, .powerup_done_in(pu),
      .dualv_check_in(dv), .lv_switch_ok_in(lv), .serial_in(serial), .year_in(year),
      .month_in(month), .rd_ocr_in(rd_ocr), .rd_cid_in(rd_cid), .rd_valid_out(vld),
      .rd_data_out(data), .cid_ready_out(rdy));
   cci_host_model host (.core_clk_in, .rd_valid_in(vld), .rd_data_in(data),
      .rd_ocr_out(rd_ocr), .rd_cid_out(rd_cid));
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end
   task automatic chk(input string n, input logic [127:0] e, g);
      compares++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask : chk
   function automatic logic [127:0] ocr_exp(input logic p, d, l);
      return {96'h0, p, p, 5'h0, l, 9'h1FF, 7'h0, d, 7'h0};
   endfunction : ocr_exp
   function automatic logic [127:0] cid_exp();
      logic [127:0] v;
      logic [6:0]   c;
      v = {72'h5A_4142_4341524430_10, serial, 4'h0, year, month, 8'h01};
      c = 7'h0;
      for (int i = 127; i >= 8; i--) c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
      v[7:1] = c;
      return v;
   endfunction : cid_exp
   task automatic tally_and_finish();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      {reset_in, clk_en_in, pu, dv, lv, dvs} = 6'h30;
      {num_errors, compares} = 0;
      void'($urandom(35));
      serial = $urandom;
      year = 8'($urandom);
      month = 4'($urandom_range(12, 1));
      repeat (8) @(negedge core_clk_in);
      reset_in = 1'b0;
      host.cmd(2'h1, ok, got);
      chk("ocr valid", 128'h1, 128'(ok));
      chk("ocr idle", ocr_exp(0, 0, 0), got);
      host.cmd(2'h2, ok, got);
      chk("early id", 128'h0, 128'(ok));
      for (int i = 0; i < 8; i++) begin
         {pu, lv, dv} = (i == 7) ? 3'h7 : (i == 0) ? 3'h0 : 3'($urandom);
         @(negedge core_clk_in);
         dvs |= dv;
         dv = 1'b0;
         repeat (8) @(negedge core_clk_in);
         host.cmd(2'h1, ok, got);
         chk("ocr", ocr_exp(pu, dvs, lv), got);
      end
      for (int n = 0; n < 300 && rdy !== 1'b1; n++) @(negedge core_clk_in);
      chk("ready", 128'h1, 128'(rdy));
      host.cmd(2'h2, ok, got);
      chk("id", cid_exp(), got);
      host.cmd(2'h3, ok, got);
      chk("id wins", cid_exp(), got);
      @(negedge core_clk_in);
      clk_en_in = 1'b0;
      host.cmd(2'h1, ok, got);
      chk("frozen", 128'h0, 128'(ok));
      clk_en_in = 1'b1;
      host.cmd(2'h1, ok, got);
      chk("ocr end", ocr_exp(1, 1, 1), got);
      tally_and_finish();
   end
endmodule : cci_card_regs_test
